/* File: inc/jtag_decode_cfg.svh */
`ifndef JTAG_DECODE_CFG_SVH
`define JTAG_DECODE_CFG_SVH
`define IR_LEN 6
`define DR_LEN 32
`define OP_EXTEST 6'h26
`define OP_PULSE 6'h3c
`define OP_TRAIN 6'h3d
`define OP_SAMPLE 6'h01
`define OP_USER_REG_FIRST 6'h02
`define OP_USER_REG_SECOND 6'h03
`define OP_USER_REG_THIRD 6'h22
`define OP_USER_REG_FOURTH 6'h23
`define OP_UCODE 6'h08
`define OP_IDENT 6'h09
`define OP_FLOAT 6'h0a
`define OP_BYPASS 6'h3f
`define OP_CFG_LOAD 6'h05
`define OP_CFG_READ 6'h04
`define OP_PROGRAM 6'h0b
`define OP_START 6'h0c
`define OP_SHUTDOWN 6'h0d
`define OP_MONITOR 6'h37
`define OP_NOOP 6'h14
`define CAPTURE_LOW 2'h1
`define USER_CODE_BLANK 32'hffffffff
`define IDENT_DEFAULT 32'h12345679
`endif

/* File: inc/jtag_decode_pkg.sv */
package jtag_decode_pkg;
  typedef enum logic [3:0] {
    test_logic_reset_state, run_idle, sel_dr, cap_dr, sh_dr, ex1_dr, pau_dr, ex2_dr, upd_dr,
    sel_ir, cap_ir, sh_ir, ex1_ir, pau_ir, ex2_ir, upd_ir
  } tap_e;
  typedef enum logic [2:0] {
    path_bypass, path_ident, path_ucode, path_config, path_boundary, path_user
  } path_e;
endpackage

/* File: verilog/jtag_instruction_decode.sv */
`timescale 1ns/1ps
`include "jtag_decode_cfg.svh"
module jtag_instruction_decode #(
  parameter logic [31:0] IDENT_VALUE = `IDENT_DEFAULT // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic done_status,
  input wire logic init_status,
  input wire logic security_enabled_flag,
  input wire logic security_done_flag,
  input wire logic configured,
  input wire logic [31:0] embedded_user_code,
  input wire logic [31:0] config_read_word,
  output logic [31:0] config_write_word,
  output logic config_write_strobe,
  output logic config_read_strobe,
  input wire logic [3:0] user_tdo,
  output logic [3:0] user_select,
  output logic user_capture,
  output logic user_shift,
  output logic user_update,
  output logic user_tdi,
  output logic boundary_select,
  output logic extest_mode,
  output logic extest_pulse_mode,
  output logic extest_train_mode,
  output logic float_user_pins,
  output logic program_trigger,
  output logic startup_clocking,
  output logic shutdown_clocking,
  output logic monitor_port_access,
  output logic [5:0] current_instr
);
  import jtag_decode_pkg::*;

  typedef struct packed {
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    tap_e tap;
    logic [5:0] ir_sh;
    logic [5:0] ir;
    logic byp;
    logic [31:0] dr;
    logic [4:0] cfg_cnt;
    logic tdo;
    logic tdo_oe;
    logic cfg_wr;
    logic cfg_rd;
    logic [31:0] cfg_word;
    logic ucap;
    logic ush;
    logic uupd;
    logic utdi;
  } state_s;

  state_s st_r, st_nxt;
  logic rise, fall, tms_i, tdi_i;
  logic user_op;
  path_e path;

  assign tms_i = st_r.tms_s[1];
  assign tdi_i = st_r.tdi_s[1];
  // tck_s[0] is only the synchroniser's first stage
  assign rise = st_r.tck_s[1] & ~st_r.tck_s[2];
  assign fall = ~st_r.tck_s[1] & st_r.tck_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // decode of the current instruction
  always_comb begin
    user_op = (st_r.ir == `OP_USER_REG_FIRST) || (st_r.ir == `OP_USER_REG_SECOND) ||
              (st_r.ir == `OP_USER_REG_THIRD) || (st_r.ir == `OP_USER_REG_FOURTH);
    unique case (st_r.ir)
      `OP_IDENT: path = path_ident;
      `OP_UCODE: path = path_ucode;
      `OP_CFG_LOAD, `OP_CFG_READ: path = path_config;
      `OP_EXTEST, `OP_SAMPLE, `OP_PULSE, `OP_TRAIN: path = path_boundary;
      `OP_USER_REG_FIRST, `OP_USER_REG_SECOND, `OP_USER_REG_THIRD, `OP_USER_REG_FOURTH: path = configured ? path_user : path_bypass;
      // float, bypass, noop, monitor, program and reserved codes all see the bypass bit
      default: path = path_bypass;
    endcase
  end

  // boundary register lives outside; it is chained through user_tdo[0] when selected
  assign boundary_select = (path == path_boundary);
  assign extest_mode = (st_r.ir == `OP_EXTEST);
  assign extest_pulse_mode = (st_r.ir == `OP_PULSE);
  assign extest_train_mode = (st_r.ir == `OP_TRAIN);
  assign float_user_pins = (st_r.ir == `OP_FLOAT);
  assign program_trigger = (st_r.ir == `OP_PROGRAM);
  assign startup_clocking = (st_r.ir == `OP_START) && (st_r.tap == run_idle);
  assign shutdown_clocking = (st_r.ir == `OP_SHUTDOWN) && (st_r.tap == run_idle);
  assign monitor_port_access = (st_r.ir == `OP_MONITOR);
  assign user_select[0] = configured && (st_r.ir == `OP_USER_REG_FIRST);
  assign user_select[1] = configured && (st_r.ir == `OP_USER_REG_SECOND);
  assign user_select[2] = configured && (st_r.ir == `OP_USER_REG_THIRD);
  assign user_select[3] = configured && (st_r.ir == `OP_USER_REG_FOURTH);
  assign current_instr = st_r.ir;
  assign tdo = st_r.tdo;
  assign tdo_oe = st_r.tdo_oe;
  assign config_write_word = st_r.cfg_word;
  assign config_write_strobe = st_r.cfg_wr;
  assign config_read_strobe = st_r.cfg_rd;
  assign user_capture = st_r.ucap;
  assign user_shift = st_r.ush;
  assign user_update = st_r.uupd;
  assign user_tdi = st_r.utdi;

  ////////////////////////////////////////////////////////////////////////////
  // tap sequencing and shift paths, one step per sampled tck edge
  always_comb begin
    logic dr_out;
    dr_out = 1'b0;
    st_nxt = st_r;
    st_nxt.tck_s = {st_r.tck_s[1:0], tck};
    st_nxt.tms_s = {st_r.tms_s[0], tms};
    st_nxt.tdi_s = {st_r.tdi_s[0], tdi};
    st_nxt.cfg_wr = 1'b0;
    st_nxt.cfg_rd = 1'b0;
    st_nxt.ucap = 1'b0;
    st_nxt.ush = 1'b0;
    st_nxt.uupd = 1'b0;
    unique case (path)
      path_bypass: dr_out = st_r.byp;
      path_user, path_boundary: dr_out = (path == path_user) ? |(user_tdo & user_select) : user_tdo[0];
      path_config: dr_out = st_r.dr[31]; // config data leaves msb first
      default: dr_out = st_r.dr[0];
    endcase
    if (rise) begin
      // program pin has no path into this machine
      unique case (st_r.tap)
        test_logic_reset_state: st_nxt.tap = tms_i ? test_logic_reset_state : run_idle;
        run_idle: st_nxt.tap = tms_i ? sel_dr : run_idle;
        sel_dr: st_nxt.tap = tms_i ? sel_ir : cap_dr;
        cap_dr: st_nxt.tap = tms_i ? ex1_dr : sh_dr;
        sh_dr: st_nxt.tap = tms_i ? ex1_dr : sh_dr;
        ex1_dr: st_nxt.tap = tms_i ? upd_dr : pau_dr;
        pau_dr: st_nxt.tap = tms_i ? ex2_dr : pau_dr;
        ex2_dr: st_nxt.tap = tms_i ? upd_dr : sh_dr;
        upd_dr: st_nxt.tap = tms_i ? sel_dr : run_idle;
        sel_ir: st_nxt.tap = tms_i ? test_logic_reset_state : cap_ir;
        cap_ir: st_nxt.tap = tms_i ? ex1_ir : sh_ir;
        sh_ir: st_nxt.tap = tms_i ? ex1_ir : sh_ir;
        ex1_ir: st_nxt.tap = tms_i ? upd_ir : pau_ir;
        pau_ir: st_nxt.tap = tms_i ? ex2_ir : pau_ir;
        ex2_ir: st_nxt.tap = tms_i ? upd_ir : sh_ir;
        upd_ir: st_nxt.tap = tms_i ? sel_dr : run_idle;
      endcase
      unique case (st_r.tap)
        cap_ir: st_nxt.ir_sh = {done_status, init_status, security_enabled_flag,
                                security_done_flag, `CAPTURE_LOW};
        sh_ir: st_nxt.ir_sh = {tdi_i, st_r.ir_sh[`IR_LEN-1:1]};
        cap_dr: begin
          st_nxt.byp = 1'b0;
          st_nxt.cfg_cnt = 5'h00;
          st_nxt.ucap = user_op && configured;
          unique case (path)
            path_ident: st_nxt.dr = IDENT_VALUE | 32'h00000001;
            path_ucode: st_nxt.dr = configured ? embedded_user_code : `USER_CODE_BLANK;
            path_config: begin
              st_nxt.dr = config_read_word;
              st_nxt.cfg_rd = (st_r.ir == `OP_CFG_READ);
            end
            default: st_nxt.dr = st_r.dr;
          endcase
        end
        sh_dr: begin
          st_nxt.byp = tdi_i;
          st_nxt.ush = (path == path_user);
          st_nxt.utdi = tdi_i;
          if (path == path_config) begin
            // config loading survives a pause-dr detour; cfg_cnt clears only in capture-dr
            st_nxt.dr = {st_r.dr[30:0], tdi_i};
            st_nxt.cfg_cnt = st_r.cfg_cnt + 5'h01;
            if (st_r.cfg_cnt == 5'h1f) begin
              // mode pins are not consulted here
              st_nxt.cfg_word = {st_r.dr[30:0], tdi_i};
              st_nxt.cfg_wr = (st_r.ir == `OP_CFG_LOAD);
              st_nxt.cfg_rd = (st_r.ir == `OP_CFG_READ);
              st_nxt.dr = config_read_word;
            end
          end else begin
            st_nxt.dr = {tdi_i, st_r.dr[31:1]};
          end
        end
        upd_dr: st_nxt.uupd = (path == path_user);
        default: st_nxt.ir_sh = st_r.ir_sh;
      endcase
    end
    if (fall) begin
      st_nxt.tdo_oe = (st_r.tap == sh_ir) || (st_r.tap == sh_dr);
      st_nxt.tdo = (st_r.tap == sh_ir) ? st_r.ir_sh[0] : dr_out;
      if (st_r.tap == upd_ir)
        st_nxt.ir = st_r.ir_sh;
      if (st_r.tap == test_logic_reset_state)
        st_nxt.ir = `OP_IDENT;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{tap: test_logic_reset_state, ir: `OP_IDENT, ir_sh: 6'h01, default: '0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule

/* File: testbench/jtag_decode_assertions.sv */
`timescale 1ns/1ps
`include "jtag_decode_cfg.svh"
module jtag_decode_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic configured,
  input wire logic [5:0] current_instr,
  input wire logic extest_mode,
  input wire logic extest_pulse_mode,
  input wire logic float_user_pins,
  input wire logic program_trigger,
  input wire logic monitor_port_access,
  input wire logic [3:0] user_select,
  input wire logic config_write_strobe,
  input wire logic config_read_strobe,
  input wire logic user_capture,
  input wire logic user_update,
  input wire logic startup_clocking
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_extest_level: assert property (extest_mode == (current_instr == `OP_EXTEST))
    else $error("extest level wrong");
  a_pulse_level: assert property (extest_pulse_mode == (current_instr == `OP_PULSE))
    else $error("pulse test level wrong");
  a_float_level: assert property (float_user_pins == (current_instr == `OP_FLOAT))
    else $error("pin float level wrong");
  a_program_level: assert property (program_trigger == (current_instr == `OP_PROGRAM))
    else $error("program level wrong");
  a_monitor_level: assert property (monitor_port_access == (current_instr == `OP_MONITOR))
    else $error("monitor level wrong");
  a_user_gate: assert property (user_select != 4'h0 |-> configured)
    else $error("user register before configuration");
  a_reset_ident: assert property ($past(rst) |-> current_instr == `OP_IDENT)
    else $error("reset instruction wrong");
  a_strobe_once: assert property (config_write_strobe |=> !config_write_strobe)
    else $error("write strobe too long");
  // one update per tck fall, and tck is at least eight clk long
  a_instr_hold: assert property (!$stable(current_instr) |=> $stable(current_instr) [*6])
    else $error("instruction changed too fast");
  a_read_pulse: assert property (config_read_strobe |=> !config_read_strobe)
    else $error("read strobe too long");
  a_user_ctl_gate: assert property ((user_capture || user_update) |-> configured)
    else $error("user control before configuration");
  a_start_instr: assert property (startup_clocking |-> current_instr == `OP_START)
    else $error("startup clocking without its instruction");
  cover property (extest_mode);
  cover property (user_select != 4'h0);
  cover property (config_write_strobe);
endmodule
bind jtag_instruction_decode jtag_decode_checker u_chk (.*);

/* File: testbench/jtag_host.sv */
`timescale 1ns/1ps
module jtag_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tdo lags a fall by about three clk, so it is taken late in the high phase
  task automatic step(input logic m, input logic b, output logic q);
    tck = 1'b0;
    tms = m;
    tdi = b;
    #160;
    tck = 1'b1;
    #159;
    q = tdo;
    #1;
  endtask
  task automatic reset5();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // from run-idle, n bits lsb first, back to run-idle; tck then stands low
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, ~tdi, q);
    tck = 1'b0;
    #320;
  endtask
endmodule

/* File: testbench/jtag_instruction_decode_test.sv */
`timescale 1ns/1ps
`include "jtag_decode_cfg.svh"
module jtag_instruction_decode_test;
  logic clk, rst, tck, tms, tdi, tdo, configured, wstb, shut;
  logic [3:0] st, usel, utdo;
  logic [5:0] instr;
  logic [31:0] ucode, rword, wword, got_w, d;
  int mismatches, check_count;
  localparam logic [31:0] ID = 32'h0abcdef1; // arbitrary value
  localparam logic [31:0] WR = 32'h5a3c9617;
  localparam logic [5:0] OPS [15] = '{`OP_EXTEST, `OP_PULSE, `OP_TRAIN, `OP_SAMPLE, `OP_UCODE, `OP_FLOAT,
    `OP_BYPASS, `OP_CFG_READ, `OP_PROGRAM, `OP_START, `OP_SHUTDOWN, `OP_MONITOR, `OP_NOOP, 6'h15, `OP_IDENT};
  localparam logic [5:0] UOPS [4] = '{`OP_USER_REG_FIRST, `OP_USER_REG_SECOND, `OP_USER_REG_THIRD, `OP_USER_REG_FOURTH};
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  jtag_instruction_decode #(.IDENT_VALUE(ID)) DUT (.clk(clk), .rst(rst), .ce(1'b1), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(), .done_status(st[3]), .init_status(st[2]), .security_enabled_flag(st[1]),
    .security_done_flag(st[0]), .configured(configured), .embedded_user_code(ucode), .config_read_word(rword),
    .config_write_word(wword), .config_write_strobe(wstb), .config_read_strobe(), .user_tdo(utdo),
    .user_select(usel), .user_capture(), .user_shift(), .user_update(), .user_tdi(), .boundary_select(),
    .extest_mode(), .extest_pulse_mode(), .extest_train_mode(), .float_user_pins(), .program_trigger(),
    .startup_clocking(), .shutdown_clocking(shut), .monitor_port_access(), .current_instr(instr));
  always @(posedge clk) if (wstb) got_w <= wword;
  ////////////////////////////////////////
  function automatic logic [31:0] rev(input logic [31:0] v);
    for (int i = 0; i < 32; i++) rev[i] = v[31 - i];
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ir(input logic [5:0] op);
    host.scan(1'b1, 6, {26'h0, op}, d);
    chk("capture", 32'h29, d);
    chk("instr", {26'h0, op}, {26'h0, instr});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #1000000;
    mismatches++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    configured = 1'b0;
    st = 4'ha;
    ucode = 32'h13572468;
    rword = 32'hc3a50f96;
    utdo = 4'h4;
    repeat (4) @(posedge clk);
    @(negedge clk) rst <= 1'b0;
    repeat (4) @(negedge clk);
    chk("reset instr", {26'h0, `OP_IDENT}, {26'h0, instr});
    host.reset5();
    host.scan(1'b0, 32, 32'h0, d);
    chk("identity", ID, d);
    // every opcode in OPS is shifted in and checked against the ir capture and current_instr
    foreach (OPS[i]) ir(OPS[i]);
    for (int k = 0; k < 2; k++) begin
      @(negedge clk) configured <= k[0];
      foreach (UOPS[i]) begin
        ir(UOPS[i]);
        chk("user select", k ? 32'(1 << i) : 32'h0, {28'h0, usel});
        host.scan(1'b0, 4, 32'h0, d);
        chk("user data", (k == 1 && i == 2) ? 32'hf : 32'h0, d);
      end
    end
    foreach (OPS[i]) if (OPS[i] == `OP_BYPASS || OPS[i] == `OP_FLOAT) begin
      ir(OPS[i]);
      host.scan(1'b0, 8, 32'hb2, d);
      chk("bypass", 32'h64, d);
    end
    ir(`OP_UCODE);
    host.scan(1'b0, 32, 32'h0, d);
    chk("user code", ucode, d);
    @(negedge clk) configured <= 1'b0;
    host.scan(1'b0, 32, 32'h0, d);
    chk("blank code", 32'hffffffff, d);
    ir(`OP_SHUTDOWN);
    chk("shutdown", 32'h1, {31'h0, shut});
    ir(`OP_CFG_LOAD);
    host.scan(1'b0, 32, rev(WR), d);
    chk("config write", WR, got_w);
    ir(`OP_CFG_READ);
    host.scan(1'b0, 32, 32'h0, d);
    chk("readback", rword, rev(d));
    ir(`OP_BYPASS);
    host.reset5();
    chk("tap reset", {26'h0, `OP_IDENT}, {26'h0, instr});
    give_verdict();
  end
endmodule
